/* bench/add_extended_and_logic_unit_test.sv */
// testbench: reference model of the slice checked over apb
`timescale 1ns/10ps
module add_extended_and_logic_unit_test;
  logic        clk = 1'b0, reset = 1'b1, clk_en = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, ca, ov, so;
  logic [7:0]  paddr;
  logic [3:0]  cond;
  logic [31:0] pwdata, prdata, a, b, res, sp [4];
  logic [31:0] exp_q [$];
  logic        err_q [$];
  int          failures = 0, n_compared = 0, seed = int'(32'h9de6754a);
  always #12.5 clk = ~clk;
  xu_apb_master u_xu_apb_master (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready);
  xu_slice u_xu_slice (.clk, .reset, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  // --------------------------------------------------
  // checking side
  // --------------------------------------------------
  always @(posedge clk) if (psel && penable && !pwrite && pready) begin
    n_compared++;
    if (prdata !== exp_q[0] || pslverr !== err_q[0]) begin
      failures++;
      $display("mismatch %0t addr %h got %h/%b exp %h/%b", $time, paddr, prdata, pslverr, exp_q[0], err_q[0]);
    end
    void'(exp_q.pop_front());
    void'(err_q.pop_front());
  end
  task wr(input logic [7:0] ad, input logic [31:0] d);
    u_xu_apb_master.xfer(1'b1, ad, d);
  endtask : wr
  task rd(input logic [7:0] ad, input logic [31:0] e);
    exp_q.push_back(e);
    err_q.push_back(ad > xu_pkg::addr_status);
    u_xu_apb_master.xfer(1'b0, ad, 32'h0);
  endtask : rd
  task run(input int k, input int o, input int r);
    logic [31:0] ad;
    logic [32:0] s;
    ad = (k == 0) ? xu_pkg::minus_one : xu_pkg::zero_addend;
    wr(xu_pkg::addr_instr, (k == 2) ? {6'h1f, 15'h0, xu_pkg::ext_and, r[0]}
      : {6'h1f, 15'h0, o[0], (k == 0) ? xu_pkg::ext_add_minus : xu_pkg::ext_add_zero, r[0]});
    if (k == 2) res = a & b;
    else begin
      s = a + ad + ca;
      res = s[31:0];
      ca = s[32];
      if (o != 0) begin
        ov = (a[31] == ad[31]) && (res[31] != a[31]);
        so = so | ov;
      end
    end
    if (r != 0) cond = {res[31], !res[31] && res != 32'h0, res == 32'h0, so};
    rd(xu_pkg::addr_result, res);
    rd(xu_pkg::addr_exc, {29'h0, so, ov, ca});
    rd(xu_pkg::addr_cond, {28'h0, cond});
  endtask : run
  task finish_test();
    if (failures == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  initial begin
    #(25 * 20000);
    failures++;
    finish_test();
  end
  // --------------------------------------------------
  // stimulus
  // --------------------------------------------------
  initial begin
    sp = '{32'h8000_0000, 32'h7fff_ffff, 32'hffff_ffff, 32'h0000_0000};
    {ca, ov, so, cond, res} = 39'h0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(xu_pkg::addr_exc, 32'h0);
    rd(8'h1c, 32'h0);
    for (int i = 0; i < 48; i++) begin
      a = (i % 8 < 4) ? sp[i % 4] : $random(seed);
      b = $random(seed);
      ca = b[7];
      wr(xu_pkg::addr_src_a, a);
      wr(xu_pkg::addr_src_b, b);
      wr(xu_pkg::addr_exc, {29'h0, so, ov, ca});
      run(i % 3, i / 3 % 2, i / 6 % 2);
    end
    // frozen enable must drop the write
    clk_en <= 1'b0;
    wr(xu_pkg::addr_src_a, ~a);
    clk_en <= 1'b1;
    rd(xu_pkg::addr_src_a, a);
    wr(xu_pkg::addr_result, 32'h1234_5678);
    rd(xu_pkg::addr_result, res);
    wr(xu_pkg::addr_instr, 32'h0);
    rd(xu_pkg::addr_status, 32'h1);
    rd(xu_pkg::addr_instr, 32'h0);
    rd(xu_pkg::addr_result, res);
    finish_test();
  end
endmodule : add_extended_and_logic_unit_test

/* bench/xu_apb_master.sv */
// apb master model standing in for the decode and issue side
`timescale 1ns/10ps
module xu_apb_master (
  // clock
  input  wire logic        clk,
  // apb
  output logic             psel    = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite  = 1'b0,
  output logic [7:0]       paddr   = 8'h00,
  output logic [31:0]      pwdata  = 32'h0,
  input  wire logic        pready
);
  // idle edge at the end so no strobe is driven twice in one step
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
    @(posedge clk);
  endtask : xfer
endmodule : xu_apb_master

/* bench/xu_slice_sva.sv */
// checker: apb answer and flag-field properties of the slice
`timescale 1ns/10ps
module xu_slice_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        clk_en,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire acc = psel && penable;
  wire rd  = acc && !pwrite;
  ready_in_access_a: assert property (acc |-> pready) else $error("no ready in access");
  unmapped_err_a: assert property (acc && paddr > 8'h18 |-> pslverr) else $error("unmapped without error");
  mapped_ok_a: assert property (acc && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped with error");
  err_read_zero_a: assert property (rd && pslverr |-> prdata == 32'h0) else $error("error read not zero");
  reset_clear_a: assert property ($fell(reset) |-> prdata == 32'h0) else $error("read data not cleared");
  prdata_hold_a: assert property (!rd && !$past(reset) |-> $stable(prdata)) else $error("read data moved");
  cond_onehot_a: assert property (rd && paddr == xu_pkg::addr_cond |-> $onehot0(prdata[3:1]))
    else $error("compare bits not one hot");
  sticky_follows_a: assert property (rd && paddr == xu_pkg::addr_exc && prdata[1] |-> prdata[2])
    else $error("signed flag without sticky");
  cover property (rd && paddr == xu_pkg::addr_result);
  cover property (acc && pwrite && paddr == xu_pkg::addr_instr);
  cover property (acc && pslverr);
endmodule : xu_slice_chk
bind xu_slice xu_slice_chk u_chk (.clk, .reset, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr);

/* src/xu_decode.sv */
// instruction decoder for the add-extended and register and forms
`timescale 1ns/10ps
module xu_decode (
  // instruction word
  input  wire logic [31:0]      instr,
  // decoded fields
  output xu_pkg::op_type        op,
  output logic                  ovf_track,
  output logic                  record_flags_bit
);

  logic [5:0] primary;
  logic [8:0] ext9;
  logic [9:0] ext10;

  always_comb begin
    primary          = instr[xu_pkg::primary_lsb +: 6];
    ext9             = instr[xu_pkg::ext9_lsb +: 9];
    ext10            = instr[xu_pkg::ext10_lsb +: 10];
    record_flags_bit = instr[xu_pkg::record_pos];
    ovf_track        = 1'b0;
    op               = xu_pkg::op_none;
    if (primary == xu_pkg::primary_code) begin
      // and has no overflow-track variant; its bit 10 is part of the code
      if (ext10 == xu_pkg::ext_and) begin
        op = xu_pkg::op_and;
      end else if (ext9 == xu_pkg::ext_add_minus) begin
        op        = xu_pkg::op_add_minus;
        ovf_track = instr[xu_pkg::ovf_track_pos];
      end else if (ext9 == xu_pkg::ext_add_zero) begin
        op        = xu_pkg::op_add_zero;
        ovf_track = instr[xu_pkg::ovf_track_pos];
      end
    end
  end

endmodule : xu_decode

/* src/xu_pkg.sv */
// package: encodings, field positions and register layout for the add-extended/and slice
//
// What this block does
// - add minus one: source plus carry minus one
// - add zero: source plus carry
// - add-extended always updates carry flag
// - overflow-track form also updates signed and sticky
// - record form updates condition field zero
// - legacy aliases behave exactly like primary forms
// - and writes logic source AND second source
// - and never touches the exception register
// - summary copies sticky; exactly one compare bit
package xu_pkg;

  // ------------------------------------------------------------
  // instruction fields (bit 0 is the lsb of the word)
  // ------------------------------------------------------------
  localparam logic [5:0]  primary_code   = 6'h1f;
  localparam logic [8:0]  ext_add_minus  = 9'h0ea;
  localparam logic [8:0]  ext_add_zero   = 9'h0ca;
  localparam logic [9:0]  ext_and        = 10'h01c;
  localparam int          primary_lsb    = 26;
  localparam int          dest_lsb       = 21;
  localparam int          src_a_lsb      = 16;
  localparam int          src_b_lsb      = 11;
  localparam int          ovf_track_pos  = 10;
  localparam int          ext9_lsb       = 1;
  localparam int          ext10_lsb      = 1;
  localparam int          record_pos     = 0;

  // ------------------------------------------------------------
  // apb register map
  // ------------------------------------------------------------
  localparam logic [7:0]  addr_instr     = 8'h00;
  localparam logic [7:0]  addr_src_a     = 8'h04;
  localparam logic [7:0]  addr_src_b     = 8'h08;
  localparam logic [7:0]  addr_result    = 8'h0c;
  localparam logic [7:0]  addr_exc       = 8'h10;
  localparam logic [7:0]  addr_cond      = 8'h14;
  localparam logic [7:0]  addr_status    = 8'h18;

  // exception register: bit 2 sticky, bit 1 signed, bit 0 carry
  localparam int          exc_sticky_pos = 2;
  localparam int          exc_signed_pos = 1;
  localparam int          exc_carry_pos  = 0;
  localparam logic [2:0]  exc_reset      = 3'h0;
  // condition field: 3 negative, 2 positive, 1 zero, 0 summary
  localparam logic [3:0]  cond_reset     = 4'h0;
  localparam logic [31:0] word_reset     = 32'h0000_0000;
  localparam logic [31:0] minus_one      = 32'hffff_ffff;
  localparam logic [31:0] zero_addend    = 32'h0000_0000;

  typedef enum logic [1:0] {
    op_none      = 2'b00,
    op_add_minus = 2'b01,
    op_add_zero  = 2'b10,
    op_and       = 2'b11
  } op_type;

endpackage : xu_pkg

/* src/xu_slice.sv */
// execution slice with apb register access
`timescale 1ns/10ps
module xu_slice (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [31:0]      instr_word;
  logic [31:0]      src_a_reg;
  logic [31:0]      second_src_reg;
  logic [31:0]      dest_reg;
  logic [2:0]       exc;
  logic [3:0]       cond;
  logic             illegal;
  logic [31:0]      next_instr_word;
  logic [31:0]      next_src_a_reg;
  logic [31:0]      next_second_src_reg;
  logic [31:0]      next_dest_reg;
  logic [2:0]       next_exc;
  logic [3:0]       next_cond;
  logic             next_illegal;
  logic [31:0]      next_prdata;
  logic [31:0]      prdata_q;

  xu_pkg::op_type   op;
  logic             ovf_track;
  logic             record_flags_bit;
  logic             wr;
  logic             rd;
  logic             issue;
  logic [32:0]      sum;
  logic [31:0]      addend;
  logic [31:0]      result;
  logic             carry_out;
  logic             signed_ovf;
  logic [2:0]       exc_after;
  logic             mapped;

  // issue by writing the instruction register; operands first
  xu_decode u_decode (
    .instr            (pwdata),
    .op               (op),
    .ovf_track        (ovf_track),
    .record_flags_bit (record_flags_bit)
  );

  // zero wait states: each access completes in its first access cycle
  always_comb begin
    pready  = 1'b1;
    mapped  = (paddr == xu_pkg::addr_instr) || (paddr == xu_pkg::addr_src_a) ||
              (paddr == xu_pkg::addr_src_b) || (paddr == xu_pkg::addr_result) ||
              (paddr == xu_pkg::addr_exc) || (paddr == xu_pkg::addr_cond) ||
              (paddr == xu_pkg::addr_status);
    pslverr = psel && penable && !mapped;
    wr      = psel && penable && pwrite && mapped && clk_en;
    // unmapped reads still decode so that they return zero
    rd      = psel && penable && !pwrite && clk_en;
    issue   = wr && (paddr == xu_pkg::addr_instr);
  end

  // ------------------------------------------------------------
  // datapath
  // ------------------------------------------------------------
  always_comb begin
    // aliases share the encoding, so one path serves both spellings
    addend = (op == xu_pkg::op_add_minus) ? xu_pkg::minus_one
                                          : xu_pkg::zero_addend;
    sum        = {1'b0, src_a_reg} + {1'b0, addend} + {32'h0000_0000, exc[xu_pkg::exc_carry_pos]};
    carry_out  = sum[32];
    signed_ovf = (src_a_reg[31] == addend[31]) && (sum[31] != src_a_reg[31]);
    // src_a_reg doubles as the logic source operand for and
    result     = (op == xu_pkg::op_and) ? (src_a_reg & second_src_reg) : sum[31:0];
    exc_after  = exc;
    if (op == xu_pkg::op_add_minus || op == xu_pkg::op_add_zero) begin
      exc_after[xu_pkg::exc_carry_pos] = carry_out;
      if (ovf_track) begin
        exc_after[xu_pkg::exc_signed_pos] = signed_ovf;
        exc_after[xu_pkg::exc_sticky_pos] = exc[xu_pkg::exc_sticky_pos] | signed_ovf;
      end
    end
    // and leaves exc_after equal to exc
  end

  always_comb begin
    next_instr_word     = instr_word;
    next_src_a_reg      = src_a_reg;
    next_second_src_reg = second_src_reg;
    next_dest_reg       = dest_reg;
    next_exc            = exc;
    next_cond           = cond;
    next_illegal        = illegal;
    next_prdata         = prdata_q;
    if (wr) begin
      case (paddr)
        xu_pkg::addr_src_a: begin
          next_src_a_reg = pwdata;
        end
        xu_pkg::addr_src_b: begin
          next_second_src_reg = pwdata;
        end
        xu_pkg::addr_exc: begin
          next_exc = pwdata[2:0];
        end
        xu_pkg::addr_cond: begin
          next_cond = pwdata[3:0];
        end
        default: begin
        end
      endcase
    end
    if (issue) begin
      next_instr_word = pwdata;
      next_illegal    = (op == xu_pkg::op_none);
      if (op != xu_pkg::op_none) begin
        next_dest_reg = result;
        next_exc      = exc_after;
        if (record_flags_bit) begin
          // sign decides negative, else nonzero is positive: exactly one set
          next_cond[3] = result[31];
          next_cond[2] = !result[31] && (result != 32'h0000_0000);
          next_cond[1] = (result == 32'h0000_0000);
          next_cond[0] = exc_after[xu_pkg::exc_sticky_pos];
        end
      end
    end
    if (rd) begin
      case (paddr)
        xu_pkg::addr_instr:  next_prdata = instr_word;
        xu_pkg::addr_src_a:  next_prdata = src_a_reg;
        xu_pkg::addr_src_b:  next_prdata = second_src_reg;
        xu_pkg::addr_result: next_prdata = dest_reg;
        xu_pkg::addr_exc:    next_prdata = {29'h0, exc};
        xu_pkg::addr_cond:   next_prdata = {28'h000_0000, cond};
        xu_pkg::addr_status: next_prdata = {31'h0, illegal};
        default:             next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // read data is registered, so it is valid one cycle after the access
  // phase; to stay apb-correct we present it combinationally below

  always_ff @(posedge clk) begin
    if (reset) begin
      instr_word     <= xu_pkg::word_reset;
      src_a_reg      <= xu_pkg::word_reset;
      second_src_reg <= xu_pkg::word_reset;
      dest_reg       <= xu_pkg::word_reset;
      exc            <= xu_pkg::exc_reset;
      cond           <= xu_pkg::cond_reset;
      illegal        <= 1'b0;
      prdata_q       <= xu_pkg::word_reset;
    end else if (clk_en) begin
      instr_word     <= next_instr_word;
      src_a_reg      <= next_src_a_reg;
      second_src_reg <= next_second_src_reg;
      dest_reg       <= next_dest_reg;
      exc            <= next_exc;
      cond           <= next_cond;
      illegal        <= next_illegal;
      prdata_q       <= next_prdata;
    end
  end

  // registers are stable during the access phase, so next_prdata is the read value
  always_comb begin
    prdata = rd ? next_prdata : prdata_q;
  end

endmodule : xu_slice
